/* File: pkg/hbs_consts.svh */
// Field constants for the host bus transaction sequencer
`ifndef HBS_CONSTS_SVH
`define HBS_CONSTS_SVH

// ==========================================================================
// Field positions and widths
`define HBS_CTRL_WIDTH       16
`define HBS_SYNC_DISABLE_BIT 12
`define HBS_DATA_WIDTH       32
`define HBS_ADDR_WIDTH       7

`endif

/* File: pkg/hbs_pkg.sv */
// Types shared by the host bus transaction sequencer
package hbs_pkg;

  // ==========================================================================
  // Sequencer states
  typedef enum logic [2:0] {
    hbsIdle,
    grant_deadband_state,
    address_wait_state,
    data_turnaround_state,
    completion_wait_state,
    release_deadband_state,
    memory_request_state,
    memory_wait_state
  } hbs_state_t;

  // Decoded host cycle kind
  typedef enum logic [1:0] {
    hbsCycExternal,
    hbsCycRegister,
    hbsCycMemory,
    hbsCycReserved
  } hbs_cycle_t;

endpackage : hbs_pkg

/* File: logic/hbs_sync.sv */
// Selectable one or two stage input synchroniser
module hbs_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             bypassSecond,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;

  initial begin
    if (WIDTH < 1) $error("hbs_sync: WIDTH must be at least 1");
  end

  // ==========================================================================
  // Two flops; inputs are active low so reset to the idle level of one
  always_ff @(posedge clk) begin
    if (srst) begin
      stage1_reg <= '1;
      stage2_reg <= '1;
    end else begin
      stage1_reg <= asyncIn;
      stage2_reg <= stage1_reg;
    end
  end

  // Mux only at the output; the first flop is still read by the second alone
  // when the second stage is in use
  assign syncOut = bypassSecond ? stage1_reg : stage2_reg;

endmodule : hbs_sync

/* File: logic/hbs_host_bus_transaction_sequencer.sv */
// Host bus transaction sequencer: grants the shared bus and runs host cycles
// Summary of operation
// RULE1: Grant dead-band floats address, data, direction, lanes; grant follows next state.
// RULE2: Address wait holds until synchronized address valid strobe is active.
// RULE3: Completion wait holds until request drops; ready and data held.
// RULE4: Release dead-band drops ready and grant; device retakes bus next cycle.
// RULE5: Memory request state pulses memory request one cycle, then memory wait.
// RULE6: Memory wait holds until memory ready active, then data turnaround.
// RULE7: Selects, direction, lane enable one stage; request and strobe one or two.
// RULE8: Host keeps selects and strobe settled and stable until grant drops.
// RULE9: Select pair decodes external, register or memory; both low reserved.
// RULE10: Request and cycle type captured entering grant dead-band; grant always follows.
// RULE11: Host that abandons a request must ignore a late grant.
// RULE12: Host drives address, direction, lanes after grant, then asserts strobe.
// RULE13: Register read drives data in turnaround, then completion wait with ready.
// RULE14: Register write leaves data bus to host; request drop marks completion.
// RULE15: Memory read data presented in memory wait, valid at ready end.
// RULE16: Memory write data valid during memory request; memory ready completes.
// RULE17: After memory ready, turnaround, completion wait for request, then release.
// RULE18: Host sends or accepts memory data valid at trailing ready edge.
// RULE19: External access floats drivers and skips straight to turnaround.
// RULE20: External access grants in turnaround and completion wait until request drops.
// RULE21: External access asserts ready only when memory ready is active.
// RULE22: Control bit 12 high disables request and strobe synchronizers; the code bypasses only their second stage, one flop remains.
// RULE23: Host request asserted requests buses, deasserted releases them.
// RULE24: Reset leaves sequencer idle, device owning bus, all strobes inactive.
// RULE25: Grant dead-band entry waits for arbitration grant and idle memory.
`include "hbs_consts.svh"

module hbs_host_bus_transaction_sequencer #(
  parameter int DATA_WIDTH = `HBS_DATA_WIDTH,
  parameter int ADDR_WIDTH = `HBS_ADDR_WIDTH
) (
  input  wire logic                  clk,
  input  wire logic                  srst,
  // Host side strobes; inputs asynchronous to clk, grant and ready registered on clk
  input  wire logic                  host_request_n,
  input  wire logic                  register_select_n,
  input  wire logic                  memory_select_n,
  input  wire logic                  address_valid_strobe_n,
  input  wire logic                  writeDirection_n,
  input  wire logic                  byte_lane_enable_0_n,
  output logic                       host_bus_grant_n,
  output logic                       host_ready_n,
  // Shared address, data, direction and lane pins (address and data each have input, output and enable; direction and lanes share ctlOe)
  input  wire logic [ADDR_WIDTH-1:0] addrIn,
  output logic      [ADDR_WIDTH-1:0] addrOut,
  output logic                       addrOe,
  input  wire logic [DATA_WIDTH-1:0] dataIn,
  output logic      [DATA_WIDTH-1:0] dataOut,
  output logic                       dataOe,
  output logic                       writeDirOut_n,
  output logic                       ctlOe,
  output logic      [3:0]            byteLanesOut_n,
  // Memory handshake
  output logic                       memory_request_n,
  input  wire logic                  memory_ready_n,
  input  wire logic [DATA_WIDTH-1:0] memReadData,
  output logic      [DATA_WIDTH-1:0] memWriteData,
  output logic                       memWriteEn,
  // Internal arbitration and register file hooks
  input  wire logic                  arbHostGrant,
  input  wire logic                  devMemBusy,
  input  wire logic [`HBS_CTRL_WIDTH-1:0] controlWord,
  input  wire logic [DATA_WIDTH-1:0] regReadData,
  output logic      [ADDR_WIDTH-1:0] regAddr,
  output logic                       regReadStb,
  output logic                       regWriteStb,
  output logic      [DATA_WIDTH-1:0] regWriteData,
  output logic                       hostOwnsBus,
  output logic                       cycleReserved
);
  import hbs_pkg::*;

  initial begin
    if (DATA_WIDTH < 16 || ADDR_WIDTH < 1) $error("hbs: unsupported widths");
  end

  // ==========================================================================
  // Synchronisers
  logic       syncDisable;
  logic [1:0] fastSync;
  logic [3:0] slowSync;
  logic       reqSync_n;
  logic       strobeSync_n;
  logic       regSelSync_n;
  logic       memSelSync_n;
  logic       wrSync_n;
  logic       laneSync_n;

  assign syncDisable = controlWord[`HBS_SYNC_DISABLE_BIT]; // see RULE22

  // Request and strobe: one or two stages by control bit 12
  hbs_sync #(.WIDTH(2)) uFastSync (  // see RULE7
    .clk          (clk),
    .srst         (srst),
    .bypassSecond (syncDisable),
    .asyncIn      ({host_request_n, address_valid_strobe_n}),
    .syncOut      (fastSync)
  );

  // Selects, direction and lane enable: always a single stage
  hbs_sync #(.WIDTH(4)) uSlowSync (  // see RULE7
    .clk          (clk),
    .srst         (srst),
    .bypassSecond (1'b1),
    .asyncIn      ({register_select_n, memory_select_n, writeDirection_n,
                    byte_lane_enable_0_n}),
    .syncOut      (slowSync)
  );

  assign reqSync_n    = fastSync[1];
  assign strobeSync_n = fastSync[0];
  assign regSelSync_n = slowSync[3];
  assign memSelSync_n = slowSync[2];
  assign wrSync_n     = slowSync[1];
  assign laneSync_n   = slowSync[0];

  // ==========================================================================
  // Cycle type decode
  function automatic hbs_cycle_t decodeCycle(input logic regN, input logic memN);
    case ({regN, memN})
      2'b11:   decodeCycle = hbsCycExternal;  // see RULE9
      2'b01:   decodeCycle = hbsCycRegister;
      2'b10:   decodeCycle = hbsCycMemory;
      default: decodeCycle = hbsCycReserved;
    endcase
  endfunction : decodeCycle

  // ==========================================================================
  // State machine
  hbs_state_t state_reg;
  hbs_state_t state_next;
  hbs_cycle_t cycle_reg;
  logic       isWrite_reg;
  logic       writeNow;

  // Direction as seen on the strobe edge; the latched copy lags by a cycle
  assign writeNow = (state_reg == address_wait_state) ? !wrSync_n : isWrite_reg;

  // Next-state decode, from synchronized host strobes; memory_ready_n is used unsynchronized
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      hbsIdle: begin
        // Wait for the arbiter and any device memory cycle to finish
        if (!reqSync_n && arbHostGrant && !devMemBusy) begin  // see RULE25
          state_next = grant_deadband_state;  // see RULE10
        end
      end
      grant_deadband_state: begin
        // Once taken, the request always runs through to a grant
        if (cycle_reg == hbsCycExternal) begin
          state_next = data_turnaround_state;  // see RULE19
        end else begin
          state_next = address_wait_state;
        end
      end
      address_wait_state: begin
        if (!strobeSync_n) begin  // see RULE2
          if (cycle_reg == hbsCycMemory) begin
            state_next = memory_request_state;
          end else begin
            state_next = data_turnaround_state;  // see RULE14
          end
        end
      end
      memory_request_state: state_next = memory_wait_state;  // see RULE5
      memory_wait_state: begin
        if (!memory_ready_n) begin  // see RULE6
          state_next = data_turnaround_state;  // see RULE17
        end
      end
      data_turnaround_state: state_next = completion_wait_state;  // see RULE13
      completion_wait_state: begin
        if (reqSync_n) begin  // see RULE3, RULE23
          state_next = release_deadband_state;  // see RULE20
        end
      end
      release_deadband_state: state_next = hbsIdle;  // see RULE4
      default: state_next = hbsIdle;
    endcase
  end

  // State register
  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= hbsIdle;  // see RULE24
    end else begin
      state_reg <= state_next;
    end
  end

  // Cycle type frozen on the edge that enters the grant dead-band
  always_ff @(posedge clk) begin
    if (srst) begin
      cycle_reg     <= hbsCycExternal;
      cycleReserved <= 1'b0;
    end else if (state_reg == hbsIdle && state_next == grant_deadband_state) begin
      cycle_reg     <= decodeCycle(regSelSync_n, memSelSync_n);  // see RULE10
      cycleReserved <= (decodeCycle(regSelSync_n, memSelSync_n) == hbsCycReserved);
    end
  end

  // Direction taken when the strobe arrives; external cycles ignore it
  always_ff @(posedge clk) begin
    if (srst) begin
      isWrite_reg <= 1'b0;
      regAddr     <= '0;
    end else if (state_reg == address_wait_state && !strobeSync_n) begin
      isWrite_reg <= !wrSync_n;  // see RULE19
      regAddr     <= addrIn;
    end
  end

  // ==========================================================================
  // Host handshake outputs, all registered from the next state
  always_ff @(posedge clk) begin
    if (srst) begin
      host_bus_grant_n <= 1'b1;
      host_ready_n     <= 1'b1;
      hostOwnsBus      <= 1'b0;
    end else begin
      // Grant from the state after the dead-band up to the release dead-band
      host_bus_grant_n <= !(state_next == address_wait_state ||
                            state_next == memory_request_state ||
                            state_next == memory_wait_state ||
                            state_next == data_turnaround_state ||
                            state_next == completion_wait_state);  // see RULE1
      hostOwnsBus      <= !(state_next == hbsIdle);
      // Ready in completion wait; external cycles only with memory ready
      if (state_next == completion_wait_state) begin
        if (cycle_reg == hbsCycExternal) begin
          host_ready_n <= memory_ready_n;  // see RULE21
        end else begin
          host_ready_n <= 1'b0;  // see RULE3
        end
      end else begin
        host_ready_n <= 1'b1;  // see RULE4
      end
    end
  end

  // Memory request pulse and write data
  always_ff @(posedge clk) begin
    if (srst) begin
      memory_request_n <= 1'b1;
      memWriteEn       <= 1'b0;
      memWriteData     <= '0;
    end else begin
      memory_request_n <= !(state_next == memory_request_state);  // see RULE5
      memWriteEn       <= (state_next == memory_request_state) && writeNow;  // see RULE16
      if (state_reg == address_wait_state) begin
        memWriteData <= dataIn;  // see RULE16
      end
    end
  end

  // ==========================================================================
  // Data path: capture returned data, drive it until release
  always_ff @(posedge clk) begin
    if (srst) begin
      dataOut <= '0;
      dataOe  <= 1'b0;
    end else begin
      if (state_reg == address_wait_state && cycle_reg == hbsCycRegister) begin
        dataOut <= regReadData;  // see RULE13
      end else if (state_reg == memory_wait_state && !memory_ready_n) begin
        dataOut <= memReadData;  // see RULE15
      end
      // Drive only for internal reads, never on external cycles
      dataOe <= !writeNow && cycle_reg != hbsCycExternal &&
                (state_next == data_turnaround_state ||
                 state_next == completion_wait_state);  // see RULE3
    end
  end

  // Register file strobes
  always_ff @(posedge clk) begin
    if (srst) begin
      regReadStb   <= 1'b0;
      regWriteStb  <= 1'b0;
      regWriteData <= '0;
    end else begin
      regReadStb  <= cycle_reg == hbsCycRegister && !writeNow &&
                     state_reg == address_wait_state && state_next == data_turnaround_state;
      // Write data is stable once the host drops its request
      regWriteStb <= cycle_reg == hbsCycRegister && isWrite_reg &&
                     state_reg == completion_wait_state && reqSync_n;  // see RULE14
      if (state_reg == completion_wait_state) begin
        regWriteData <= dataIn;
      end
    end
  end

  // ==========================================================================
  // Device-owned pins: driven only while idle; floated from dead-band onward
  always_ff @(posedge clk) begin
    if (srst) begin
      addrOe         <= 1'b1;
      ctlOe          <= 1'b1;
      addrOut        <= '0;
      writeDirOut_n  <= 1'b1;
      byteLanesOut_n <= '1;
    end else begin
      addrOe         <= (state_next == hbsIdle);  // see RULE1
      ctlOe          <= (state_next == hbsIdle);  // see RULE4
      addrOut        <= '0;
      writeDirOut_n  <= 1'b1;
      byteLanesOut_n <= {3'h7, laneSync_n | 1'b1};
    end
  end

endmodule : hbs_host_bus_transaction_sequencer

/* File: tb/hbs_host_bus_transaction_sequencer_properties.sv */
// Port level checks for the host bus transaction sequencer
module hbs_seq_properties (
  input wire logic clk,
  input wire logic srst,
  input wire logic host_request_n,
  input wire logic register_select_n,
  input wire logic memory_select_n,
  input wire logic host_bus_grant_n,
  input wire logic host_ready_n,
  input wire logic addrOe,
  input wire logic ctlOe,
  input wire logic memory_request_n,
  input wire logic memory_ready_n,
  input wire logic arbHostGrant,
  input wire logic devMemBusy,
  input wire logic hostOwnsBus
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // ==========================================================================
  // Grant and release
  chk_reset_idle: assert property ($fell(srst) |->
    host_bus_grant_n && host_ready_n && memory_request_n) else $error("strobe active after reset");
  chk_float_first: assert property ($fell(host_bus_grant_n) |->
    !$past(addrOe) && !$past(ctlOe)) else $error("grant without a floated dead-band");
  chk_arb_gate: assert property ($fell(host_bus_grant_n) |->
    $past(arbHostGrant, 2) && !$past(devMemBusy, 2)) else $error("grant without arbitration");
  chk_grant_follows: assert property ($rose(hostOwnsBus) |=> !host_bus_grant_n)
    else $error("no grant after dead-band");
  chk_release_pair: assert property ($rose(host_bus_grant_n) |-> host_ready_n)
    else $error("ready outlives grant");
  chk_ready_hold: assert property (!host_ready_n && !host_request_n && !register_select_n
    |=> !host_ready_n) else $error("ready dropped while request held");

  // ==========================================================================
  // Memory and external cycles
  chk_memreq_pulse: assert property (!memory_request_n |=> memory_request_n)
    else $error("memory request longer than one cycle");
  chk_memreq_type: assert property (!memory_request_n |-> !memory_select_n
    && register_select_n && !host_bus_grant_n && hostOwnsBus) else $error("memory request on wrong cycle");
  chk_memwait_hold: assert property (!memory_request_n ##1 memory_ready_n [*3]
    |-> host_ready_n) else $error("left memory wait early");
  chk_mem_to_ready: assert property ($fell(memory_ready_n) && !memory_select_n
    && !host_request_n |-> ##[1:4] !host_ready_n) else $error("no ready after memory ready");
  chk_ext_ready: assert property (!host_ready_n && register_select_n && memory_select_n
    |-> !$past(memory_ready_n)) else $error("external ready without memory ready");

  cover property (!memory_request_n);
  cover property (!host_ready_n && register_select_n && memory_select_n);
  cover property ($rose(hostOwnsBus) && !register_select_n);
endmodule : hbs_seq_properties

bind hbs_host_bus_transaction_sequencer hbs_seq_properties chk (.clk, .srst, .host_request_n,
  .register_select_n, .memory_select_n, .host_bus_grant_n, .host_ready_n, .addrOe, .ctlOe,
  .memory_request_n, .memory_ready_n, .arbHostGrant, .devMemBusy, .hostOwnsBus);

/* File: tb/hbs_host_model.sv */
// Host bus controller and memory responder facing the sequencer
module hbs_host_model (
  input  wire logic        clk,
  input  wire logic        host_bus_grant_n,
  input  wire logic        host_ready_n,
  input  wire logic        memory_request_n,
  input  wire logic [31:0] dataOut,
  output logic             host_request_n,
  output logic             register_select_n,
  output logic             memory_select_n,
  output logic             address_valid_strobe_n,
  output logic             writeDirection_n,
  output logic             byte_lane_enable_0_n,
  output logic             memory_ready_n,
  output logic [31:0]      dataIn
);
  timeunit 1ns;
  timeprecision 1ps;
  int memDelay = 0;

  // Idle host: everything released, pulled-up strobes high
  initial begin
    {host_request_n, register_select_n, memory_select_n, address_valid_strobe_n} = 4'hf;
    {writeDirection_n, byte_lane_enable_0_n, memory_ready_n} = 3'h7;
    dataIn = 32'h0;
  end

  task automatic step();
    @(posedge clk);
    #1;
  endtask : step

  // One host cycle; waits are bounded so a dead design cannot hang the run
  task automatic run(input logic rn, mn, wr, ack, input logic [31:0] wd,
                     output logic [31:0] rd, output logic sawReady);
    int n;
    step();
    register_select_n = rn;
    memory_select_n = mn;
    host_request_n = 1'b0;
    for (n = 0; n < 40 && host_bus_grant_n !== 1'b0; n++) step(); // late grant waited out
    writeDirection_n = !wr;
    byte_lane_enable_0_n = 1'b0;
    dataIn = wd;
    step();
    address_valid_strobe_n = 1'b0;
    if (ack) memory_ready_n = 1'b0; // external device answers
    for (n = 0; n < 40 && host_ready_n !== 1'b0; n++) step();
    sawReady = (host_ready_n === 1'b0);
    rd = dataOut;
    host_request_n = 1'b1;
    for (n = 0; n < 40 && host_bus_grant_n !== 1'b1; n++) step();
    // Everything but the request stays put until the grant drops
    {address_valid_strobe_n, writeDirection_n, byte_lane_enable_0_n, memory_ready_n} = 4'hf;
    {register_select_n, memory_select_n} = 2'h3;
    dataIn = ~wd; // a released bus never keeps its last value
  endtask : run

  // Memory side: one cycle ready after memDelay edges
  always @(posedge clk) begin
    if (memory_request_n === 1'b0) begin
      repeat (memDelay) @(posedge clk);
      #1;
      memory_ready_n = 1'b0;
      @(posedge clk);
      #1;
      memory_ready_n = 1'b1;
    end
  end
endmodule : hbs_host_model

/* File: tb/hbs_host_bus_transaction_sequencer_test.sv */
// Self-checking bench for the host bus transaction sequencer
`include "hbs_consts.svh"
module hbs_host_bus_transaction_sequencer_test;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic       rn, mn, wr, b12, ack, expRdy, expRes;
    logic [3:0] dly;
  } hbs_row_t;
  // Register read, register write, memory read and write, external with and
  // without an answer, reserved type
  localparam hbs_row_t ROWS [7] = '{
    '{1'h0, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0, 4'h0}, '{1'h0, 1'h1, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0, 4'h0},
    '{1'h1, 1'h0, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0, 4'h0}, '{1'h1, 1'h0, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0, 4'h3},
    '{1'h1, 1'h1, 1'h0, 1'h1, 1'h1, 1'h1, 1'h0, 4'h0}, '{1'h1, 1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 4'h0},
    '{1'h0, 1'h0, 1'h1, 1'h1, 1'h0, 1'h1, 1'h1, 4'h0}};
  logic clk = 1'b0, srst = 1'b1, arbHostGrant = 1'b1, devMemBusy = 1'b0;
  logic [15:0] controlWord = 16'h0;
  logic [6:0] addrIn = 7'h11;
  logic [31:0] memReadData = 32'hc3c3_1234, regReadData = 32'h5a5a_0f0f;
  logic host_request_n, register_select_n, memory_select_n, address_valid_strobe_n;
  logic writeDirection_n, byte_lane_enable_0_n, memory_ready_n, host_bus_grant_n, host_ready_n;
  logic addrOe, dataOe, ctlOe, memory_request_n, memWriteEn, regWriteStb, hostOwnsBus;
  logic cycleReserved, rdy;
  logic [31:0] dataIn, dataOut, memWriteData, regWriteData, wrSeen, memWrSeen, rd, wd;
  logic [31:0] mreqCnt = 32'h0;
  int numErrors = 0, testsRun = 0, cycles = 0;
  hbs_row_t r;

  hbs_host_bus_transaction_sequencer dut (.clk, .srst, .host_request_n, .register_select_n,
    .memory_select_n, .address_valid_strobe_n, .writeDirection_n, .byte_lane_enable_0_n,
    .host_bus_grant_n, .host_ready_n, .addrIn, .addrOut(), .addrOe, .dataIn, .dataOut, .dataOe,
    .writeDirOut_n(), .ctlOe, .byteLanesOut_n(), .memory_request_n, .memory_ready_n, .memReadData,
    .memWriteData, .memWriteEn, .arbHostGrant, .devMemBusy, .controlWord, .regReadData,
    .regAddr(), .regReadStb(), .regWriteStb, .regWriteData, .hostOwnsBus, .cycleReserved);
  hbs_host_model host (.clk, .host_bus_grant_n, .host_ready_n, .memory_request_n, .dataOut,
    .host_request_n, .register_select_n, .memory_select_n, .address_valid_strobe_n,
    .writeDirection_n, .byte_lane_enable_0_n, .memory_ready_n, .dataIn);

  always #4 clk = ~clk;

  // Capture what the design hands to the register file and memory
  always @(posedge clk) begin
    if (regWriteStb === 1'b1) wrSeen <= regWriteData;
    if (memWriteEn === 1'b1) memWrSeen <= memWriteData;
    if (memory_request_n === 1'b0) mreqCnt <= mreqCnt + 32'h1;
  end

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      numErrors++;
      stop_test();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, exp);
    testsRun++;
    if (seen !== exp) begin
      numErrors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic reset_dut(input int n);
    srst = 1'b1;
    repeat (n) host.step();
    check("reset", {host_bus_grant_n, host_ready_n, memory_request_n, addrOe, dataOe}, 5'h1e);
    srst = 1'b0;
  endtask : reset_dut

  task automatic stop_test();
    $display("Comparisons %0d mismatches %0d", testsRun, numErrors);
    if (numErrors == 0 && testsRun > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test

  // ==========================================================================
  // Main sequence
  initial begin
    reset_dut(12);
    for (int i = 0; i < 7; i++) begin
      r = ROWS[i];
      wd = 32'ha5c3_0000 + 32'(i);
      controlWord[`HBS_SYNC_DISABLE_BIT] = r.b12;
      host.memDelay = int'(r.dly);
      mreqCnt = 32'h0;
      host.run(r.rn, r.mn, r.wr, r.ack, wd, rd, rdy);
      host.step();
      check("ready", rdy, r.expRdy);
      check("reserved", cycleReserved, r.expRes);
      check("memreq", mreqCnt, {31'h0, !r.mn && r.rn});
      if (!r.wr && !r.rn && r.mn) check("regread", rd, regReadData);
      if (!r.wr && r.rn && !r.mn) check("memread", rd, memReadData);
      if (r.wr && !r.rn && r.mn) check("regwrite", wrSeen, wd);
      if (r.wr && r.rn && !r.mn) check("memwrite", memWrSeen, wd);
    end
    // Busy memory and a withheld arbitration grant hold the host off
    {devMemBusy, arbHostGrant} = 2'h2;
    fork
      host.run(1'h0, 1'h1, 1'h0, 1'h0, 32'h0, rd, rdy);
      begin
        repeat (10) host.step();
        check("heldoff", host_bus_grant_n, 1'h1);
        {devMemBusy, arbHostGrant} = 2'h1;
      end
    join
    check("lateread", rd, regReadData);
    // Reset in mid-cycle returns the bus to the device at once
    fork
      host.run(1'h0, 1'h1, 1'h1, 1'h0, 32'h1, rd, rdy);
      begin
        repeat (6) host.step();
        reset_dut(2);
      end
    join
    stop_test();
  end
endmodule : hbs_host_bus_transaction_sequencer_test
